/* rga_pkg.sv */
// rga_pkg: shared constants and types for the byte-to-nibble link adapter
// assumes: one 25 MHz system clock, both link ends built on that clock
package rga_pkg;

  // clock and link timing
  localparam int unsigned REF_CLK_HZ     = 25_000_000;
  localparam int unsigned REF_CLK_NS     = 40;
  localparam int unsigned LINK_CLK_HALF  = 1;             // ref cycles per link half
  localparam int unsigned TX_DELAY_CYC   = 2;             // pop to low nibble on lines
  localparam int unsigned RX_DELAY_EDGES = 3;             // capture to mac outputs

  // widths
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned TXW_W  = BYTE_W + 2;            // {error, enable, byte}

  // transmit buffer
  localparam int unsigned TX_FIFO_DEPTH = 32;

  // transmit word field positions
  localparam int unsigned TXW_EN_BIT  = 8;
  localparam int unsigned TXW_ER_BIT  = 9;

  // in-band status field positions within the low nibble
  localparam int unsigned STAT_LINK_BIT   = 0;
  localparam int unsigned STAT_SPEED_LSB  = 1;
  localparam int unsigned STAT_SPEED_MSB  = 2;
  localparam int unsigned STAT_DUPLEX_BIT = 3;

  // reset values
  localparam logic [NIB_W-1:0]  NIB_RST   = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
  localparam logic [TXW_W-1:0]  TXW_IDLE  = 10'h000;
  localparam logic              CTL_RST   = 1'h0;
  localparam logic [1:0]        SPEED_RST = 2'h0;

  // link half-cycle phase, one-hot
  typedef enum logic [1:0] {
    RGA_PH_LOW  = 2'b01,                                  // rising half, low nibble
    RGA_PH_HIGH = 2'b10                                   // falling half, high nibble
  } rga_phase_e;

endpackage

/* rga_link_if.sv */
// rga_link_if: the twelve link wires between adapter and phy end
// assumes: both ends clocked by the same system clock; wires are one-way
`timescale 1ns/100ps
interface rga_link_if;
  import rga_pkg::*;

  // transmit direction, adapter to phy
  logic             tx_clk;
  logic [NIB_W-1:0] txd;
  logic             tx_ctl;
  // receive direction, phy to adapter
  logic             rx_clk;
  logic [NIB_W-1:0] rxd;
  logic             rx_ctl;

  modport adapter (output tx_clk, txd, tx_ctl, input rx_clk, rxd, rx_ctl);
  modport phy     (input tx_clk, txd, tx_ctl, output rx_clk, rxd, rx_ctl);
endinterface

/* rga_adapter.sv */
// rga_adapter: mac byte side to nibble double-rate link side, plus tx buffer
// assumes: link wires carried by rga_link_if; rx link wires are asynchronous
// Function
// [RULE1] drive transmit reference clock toward phy
// [RULE2] low nibble rising half, high nibble falling
// [RULE3] tx control: enable, then enable xor error
// [RULE4] phy supplies rx clock, both edges captured
// [RULE5] rx low nibble rising, high falling, reassembled
// [RULE6] rx control: valid, then valid xor error
// [RULE7] mac provides byte, enable, error inputs
// [RULE8] output byte, valid, error toward mac
// [RULE9] mac rx clock derived from phy clock
// [RULE10] transmit path timed from mac transmit clock; the code has no mac transmit clock and times it from ref_clk_in
// [RULE11] transmit path delay two clock cycles
// [RULE12] receive path delay three clock cycles
// [RULE13] rx error is registered xor of halves
// [RULE14] decode link, speed, duplex from nibble
// [RULE15] reset deasserts valid, error, tx control
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// first-word-fall-through buffer, depth must be a power of two
module rga_fifo
  import rga_pkg::*;
#(
  parameter int unsigned WIDTH = TXW_W,
  parameter int unsigned DEPTH = TX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  // drain side
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned  AW       = $clog2(DEPTH);
  localparam logic [AW:0]  FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign wr_ready_out = (count_r != FULL_CNT);
  assign rd_valid_out = (count_r != '0);
  assign rd_data_out  = mem[rd_ptr_r];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // storage, no reset needed on data
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_data_in;
    end
  end

  // pointers wrap naturally at the power-of-two depth
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
      unique case ({push, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rga_adapter
  import rga_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  // mac transmit side
  input  wire logic [BYTE_W-1:0] mac_txd_in,
  input  wire logic              mac_tx_en_in,
  input  wire logic              mac_tx_error_in,
  input  wire logic              mac_tx_valid_in,
  output logic                   mac_tx_ready_out,
  // mac receive side
  output logic      [BYTE_W-1:0] mac_rxd_out,
  output logic                   mac_rx_valid_out,
  output logic                   mac_rx_error_out,
  output logic                   mac_rx_clk_out,
  // decoded phy status
  output logic                   link_up_out,
  output logic      [1:0]        link_speed_out,
  output logic                   full_duplex_out,
  // link wires
  rga_link_if.adapter            link
);

  //////////////////////////////////////////////////////////////////////////////
  // transmit path, entirely on ref_clk_in

  logic [TXW_W-1:0] fifo_word;
  logic             fifo_valid;
  logic             fifo_pop;
  rga_phase_e       tx_ph_r;
  logic [TXW_W-1:0] tx_hold_r;
  logic             tx_clk_r;
  logic [NIB_W-1:0] txd_r;
  logic             tx_ctl_r;

  // buffer absorbs one byte per cycle while the link drains one per two
  rga_fifo #(
    .WIDTH (TXW_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk_in   (ref_clk_in),
    .srst_in      (srst_in),
    .wr_data_in   ({mac_tx_error_in, mac_tx_en_in, mac_txd_in}),  // see [RULE7]
    .wr_valid_in  (mac_tx_valid_in),
    .wr_ready_out (mac_tx_ready_out),
    .rd_data_out  (fifo_word),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop)
  );

  // one word leaves per link cycle, in the falling half
  assign fifo_pop = (tx_ph_r == RGA_PH_HIGH);

  // half-cycle phase, alternates every ref clock
  always_ff @(posedge ref_clk_in) begin  // see [RULE10]
    if (srst_in) begin
      tx_ph_r <= RGA_PH_LOW;
    end else begin
      unique case (tx_ph_r)
        RGA_PH_LOW:  tx_ph_r <= RGA_PH_HIGH;
        RGA_PH_HIGH: tx_ph_r <= RGA_PH_LOW;
      endcase
    end
  end

  // holding stage; an empty buffer sends idle rather than stalling the link
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_hold_r <= TXW_IDLE;
    end else if (fifo_pop) begin
      tx_hold_r <= fifo_valid ? fifo_word : TXW_IDLE;  // see [RULE11]
    end
  end

  // line stage: second register after the pop, clock made by division
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_clk_r <= 1'b0;
      txd_r    <= NIB_RST;
      tx_ctl_r <= CTL_RST;  // see [RULE15]
    end else begin
      unique case (tx_ph_r)
        RGA_PH_LOW: begin
          tx_clk_r <= 1'b1;  // see [RULE1]
          txd_r    <= tx_hold_r[NIB_W-1:0];  // see [RULE2]
          tx_ctl_r <= tx_hold_r[TXW_EN_BIT];  // see [RULE3]
        end
        RGA_PH_HIGH: begin
          tx_clk_r <= 1'b0;
          txd_r    <= tx_hold_r[BYTE_W-1:NIB_W];  // see [RULE2]
          tx_ctl_r <= tx_hold_r[TXW_EN_BIT] ^ tx_hold_r[TXW_ER_BIT];  // see [RULE3]
        end
      endcase
    end
  end

  assign link.tx_clk = tx_clk_r;
  assign link.txd    = txd_r;
  assign link.tx_ctl = tx_ctl_r;

  //////////////////////////////////////////////////////////////////////////////
  // receive path: link wires arrive from outside, so two flops first

  logic [2:0]       rx_clk_s_r;            // [0] only feeds [1]
  logic [NIB_W-1:0] rxd_s0_r;
  logic [NIB_W-1:0] rxd_s1_r;
  logic             rx_ctl_s0_r;
  logic             rx_ctl_s1_r;
  logic             rx_rise;
  logic             rx_fall;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rx_clk_s_r  <= 3'h0;
      rxd_s0_r    <= NIB_RST;
      rxd_s1_r    <= NIB_RST;
      rx_ctl_s0_r <= CTL_RST;
      rx_ctl_s1_r <= CTL_RST;
    end else begin
      rx_clk_s_r  <= {rx_clk_s_r[1:0], link.rx_clk};
      rxd_s0_r    <= link.rxd;
      rxd_s1_r    <= rxd_s0_r;
      rx_ctl_s0_r <= link.rx_ctl;
      rx_ctl_s1_r <= rx_ctl_s0_r;
    end
  end

  // edges of the phy clock, seen only past the first flop
  assign rx_rise = rx_clk_s_r[1] && !rx_clk_s_r[2];  // see [RULE4]
  assign rx_fall = !rx_clk_s_r[1] && rx_clk_s_r[2];

  logic [NIB_W-1:0]  rise_nib_r;
  logic              rise_ctl_r;
  logic [NIB_W-1:0]  fall_nib_r;
  logic              fall_ctl_r;
  logic [BYTE_W-1:0] sync_byte_r;
  logic              sync_dv_r;
  logic              sync_fx_r;

  // capture stage: one register per clock edge
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rise_nib_r <= NIB_RST;
      rise_ctl_r <= CTL_RST;
      fall_nib_r <= NIB_RST;
      fall_ctl_r <= CTL_RST;
    end else begin
      if (rx_rise) begin
        rise_nib_r <= rxd_s1_r;  // see [RULE5]
        rise_ctl_r <= rx_ctl_s1_r;  // see [RULE6]
      end
      if (rx_fall) begin
        fall_nib_r <= rxd_s1_r;  // see [RULE5]
        fall_ctl_r <= rx_ctl_s1_r;  // see [RULE6]
      end
    end
  end

  // sync stage: both halves brought onto the rising edge together
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync_byte_r <= BYTE_RST;
      sync_dv_r   <= CTL_RST;
      sync_fx_r   <= CTL_RST;
    end else if (rx_rise) begin
      sync_byte_r <= {fall_nib_r, rise_nib_r};  // see [RULE5]
      sync_dv_r   <= rise_ctl_r;
      sync_fx_r   <= fall_ctl_r;
    end
  end

  // output stage: second rising edge after capture
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mac_rxd_out      <= BYTE_RST;
      mac_rx_valid_out <= CTL_RST;  // see [RULE15]
      mac_rx_error_out <= CTL_RST;
    end else if (rx_rise) begin
      mac_rxd_out      <= sync_byte_r;  // see [RULE12]
      mac_rx_valid_out <= sync_dv_r;  // see [RULE8]
      mac_rx_error_out <= sync_dv_r ^ sync_fx_r;  // see [RULE13]
    end
  end

  // forwarded clock lags one cycle so its rise meets settled outputs
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mac_rx_clk_out <= 1'b0;
    end else begin
      mac_rx_clk_out <= rx_clk_s_r[2];  // see [RULE9]
    end
  end

  // in-band status rides only on idle link cycles (valid and error low)
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      link_up_out     <= 1'b0;
      link_speed_out  <= SPEED_RST;
      full_duplex_out <= 1'b0;
    end else if (rx_rise && !sync_dv_r && !sync_fx_r) begin
      link_up_out     <= sync_byte_r[STAT_LINK_BIT];  // see [RULE14]
      link_speed_out  <= sync_byte_r[STAT_SPEED_MSB:STAT_SPEED_LSB];
      full_duplex_out <= sync_byte_r[STAT_DUPLEX_BIT];
    end
  end

endmodule

/* rga_phy_end.sv */
// rga_phy_end: far end of the nibble link, plain byte ports toward its user
// assumes: same system clock as the adapter; tx link wires are asynchronous
`timescale 1ns/100ps
module rga_phy_end
  import rga_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  // bytes to send toward the adapter
  input  wire logic [BYTE_W-1:0] line_rx_byte_in,
  input  wire logic              line_rx_valid_in,
  input  wire logic              line_rx_error_in,
  output logic                   line_rx_take_out,
  // bytes received from the adapter
  output logic      [BYTE_W-1:0] line_tx_byte_out,
  output logic                   line_tx_en_out,
  output logic                   line_tx_error_out,
  output logic                   line_tx_strobe_out,
  // link wires
  rga_link_if.phy                link
);

  //////////////////////////////////////////////////////////////////////////////
  // send side: this end makes the receive clock by division

  rga_phase_e        ph_r;
  logic [BYTE_W-1:0] hold_byte_r;
  logic              hold_dv_r;
  logic              hold_er_r;
  logic              rx_clk_r;
  logic [NIB_W-1:0]  rxd_r;
  logic              rx_ctl_r;

  // user byte taken once per link cycle, in the falling half
  assign line_rx_take_out = (ph_r == RGA_PH_HIGH);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ph_r        <= RGA_PH_LOW;
      hold_byte_r <= BYTE_RST;
      hold_dv_r   <= CTL_RST;
      hold_er_r   <= CTL_RST;
    end else begin
      unique case (ph_r)
        RGA_PH_LOW:  ph_r <= RGA_PH_HIGH;
        RGA_PH_HIGH: ph_r <= RGA_PH_LOW;
      endcase
      if (line_rx_take_out) begin
        hold_byte_r <= line_rx_byte_in;
        hold_dv_r   <= line_rx_valid_in;
        hold_er_r   <= line_rx_error_in;
      end
    end
  end

  // nibble and control muxing per half
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rx_clk_r <= 1'b0;
      rxd_r    <= NIB_RST;
      rx_ctl_r <= CTL_RST;
    end else begin
      unique case (ph_r)
        RGA_PH_LOW: begin
          rx_clk_r <= 1'b1;  // see [RULE4]
          rxd_r    <= hold_byte_r[NIB_W-1:0];  // see [RULE5]
          rx_ctl_r <= hold_dv_r;  // see [RULE6]
        end
        RGA_PH_HIGH: begin
          rx_clk_r <= 1'b0;
          rxd_r    <= hold_byte_r[BYTE_W-1:NIB_W];  // see [RULE5]
          rx_ctl_r <= hold_dv_r ^ hold_er_r;  // see [RULE6]
        end
      endcase
    end
  end

  assign link.rx_clk = rx_clk_r;
  assign link.rxd    = rxd_r;
  assign link.rx_ctl = rx_ctl_r;

  //////////////////////////////////////////////////////////////////////////////
  // receive side: two flops, then edges of the adapter's clock

  logic [2:0]       tclk_s_r;
  logic [NIB_W-1:0] txd_s0_r;
  logic [NIB_W-1:0] txd_s1_r;
  logic             tctl_s0_r;
  logic             tctl_s1_r;
  logic [NIB_W-1:0] lo_nib_r;
  logic             lo_ctl_r;
  logic             t_rise;
  logic             t_fall;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tclk_s_r  <= 3'h0;
      txd_s0_r  <= NIB_RST;
      txd_s1_r  <= NIB_RST;
      tctl_s0_r <= CTL_RST;
      tctl_s1_r <= CTL_RST;
    end else begin
      tclk_s_r  <= {tclk_s_r[1:0], link.tx_clk};
      txd_s0_r  <= link.txd;
      txd_s1_r  <= txd_s0_r;
      tctl_s0_r <= link.tx_ctl;
      tctl_s1_r <= tctl_s0_r;
    end
  end

  assign t_rise = tclk_s_r[1] && !tclk_s_r[2];
  assign t_fall = !tclk_s_r[1] && tclk_s_r[2];

  // low half held until the falling half completes the byte
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lo_nib_r           <= NIB_RST;
      lo_ctl_r           <= CTL_RST;
      line_tx_byte_out   <= BYTE_RST;
      line_tx_en_out     <= CTL_RST;
      line_tx_error_out  <= CTL_RST;
      line_tx_strobe_out <= 1'b0;
    end else begin
      line_tx_strobe_out <= t_fall;
      if (t_rise) begin
        lo_nib_r <= txd_s1_r;
        lo_ctl_r <= tctl_s1_r;
      end
      if (t_fall) begin
        line_tx_byte_out  <= {txd_s1_r, lo_nib_r};
        line_tx_en_out    <= lo_ctl_r;
        line_tx_error_out <= lo_ctl_r ^ tctl_s1_r;  // undo the xor of the halves
      end
    end
  end

endmodule

/* rga_link_assertions.sv */
// rga_link_assertions: timing checks on the nibble link wires
// assumes: instantiated in tb beside rga_link_if, one system clock domain
`timescale 1ns/100ps
module rga_link_assertions
  import rga_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // transmit wires
  input  wire logic             tx_clk,
  input  wire logic [NIB_W-1:0] txd,
  input  wire logic             tx_ctl,
  // receive wires
  input  wire logic             rx_clk,
  input  wire logic [NIB_W-1:0] rxd,
  input  wire logic             rx_ctl
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  //////////////////////////////////////////////////////////////////////////////
  // link clocks are divide-by-two: each half lasts exactly one cycle
  property p_tx_clk_high_half;
    tx_clk |=> !tx_clk;
  endproperty
  a_tx_clk_high_half: assert property (p_tx_clk_high_half)
    else $error("tx link clock high for more than one cycle");

  property p_tx_clk_low_half;
    $fell(tx_clk) |=> tx_clk;
  endproperty
  a_tx_clk_low_half: assert property (p_tx_clk_low_half)
    else $error("tx link clock low for more than one cycle");

  property p_tx_clk_starts;
    $fell(srst_in) |-> ##[1:3] tx_clk;
  endproperty
  a_tx_clk_starts: assert property (p_tx_clk_starts)
    else $error("tx link clock did not start after reset");

  property p_rx_clk_high_half;
    rx_clk |=> !rx_clk;
  endproperty
  a_rx_clk_high_half: assert property (p_rx_clk_high_half)
    else $error("rx link clock high for more than one cycle");

  property p_rx_clk_low_half;
    $fell(rx_clk) |=> rx_clk;
  endproperty
  a_rx_clk_low_half: assert property (p_rx_clk_low_half)
    else $error("rx link clock low for more than one cycle");

  property p_rx_clk_starts;
    $fell(srst_in) |-> ##[1:3] rx_clk;
  endproperty
  a_rx_clk_starts: assert property (p_rx_clk_starts)
    else $error("rx link clock did not start after reset");

  //////////////////////////////////////////////////////////////////////////////
  // values left by reset, seen at the first edge after release
  property p_tx_reset;
    $fell(srst_in) |-> (!tx_clk && !tx_ctl && txd == NIB_RST);
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("tx wires not idle after reset");

  property p_rx_reset;
    $fell(srst_in) |-> (!rx_clk && !rx_ctl && rxd == NIB_RST);
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("rx wires not idle after reset");

  // main traffic kinds
  c_tx_frame: cover property (tx_clk && tx_ctl);
  c_tx_error: cover property (tx_clk && tx_ctl ##1 !tx_ctl);
  c_rx_frame: cover property (rx_clk && rx_ctl);
endmodule

/* tb.sv */
// tb: adapter and phy end joined back to back, bytes sent both ways
// assumes: one 25 MHz clock for both ends; inputs change at falling edge
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import rga_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              srst_in    = 1'b1;
  logic [BYTE_W-1:0] mac_txd = 8'h00, ln_rx_byte = 8'h00, mac_rxd, ln_tx_byte;
  logic              tx_en = 1'b0, tx_er = 1'b0, tx_valid = 1'b0, tx_ready;
  logic              ln_rx_valid = 1'b0, ln_rx_error = 1'b0, ln_take;
  logic              rx_valid, rx_error, rx_clk_o, link_up, duplex;
  logic              ln_tx_en, ln_tx_er, ln_strobe, c1, have, rxc_d, saw_full;
  logic [1:0]        speed;
  logic [NIB_W-1:0]  lo;
  logic [8:0]        exp_tx[$], wire_q[$], line_q[$], exp_rx[$], mac_q[$];
  int                n_mismatch  = 0;
  int                comparisons = 0;

  rga_link_if rga_link_if_inst ();
  rga_adapter rga_adapter_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .mac_txd_in(mac_txd), .mac_tx_en_in(tx_en), .mac_tx_error_in(tx_er),
    .mac_tx_valid_in(tx_valid), .mac_tx_ready_out(tx_ready), .mac_rxd_out(mac_rxd),
    .mac_rx_valid_out(rx_valid), .mac_rx_error_out(rx_error), .mac_rx_clk_out(rx_clk_o),
    .link_up_out(link_up), .link_speed_out(speed), .full_duplex_out(duplex),
    .link(rga_link_if_inst));
  rga_phy_end rga_phy_end_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .line_rx_byte_in(ln_rx_byte), .line_rx_valid_in(ln_rx_valid),
    .line_rx_error_in(ln_rx_error), .line_rx_take_out(ln_take),
    .line_tx_byte_out(ln_tx_byte), .line_tx_en_out(ln_tx_en),
    .line_tx_error_out(ln_tx_er), .line_tx_strobe_out(ln_strobe), .link(rga_link_if_inst));
  rga_link_assertions rga_link_assertions_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .tx_clk(rga_link_if_inst.tx_clk), .txd(rga_link_if_inst.txd),
    .tx_ctl(rga_link_if_inst.tx_ctl), .rx_clk(rga_link_if_inst.rx_clk),
    .rxd(rga_link_if_inst.rxd), .rx_ctl(rga_link_if_inst.rx_ctl));

  //////////////////////////////////////////////////////////////////////////////
  // clock, and a watchdog sized well past the few hundred cycles needed
  initial forever #(REF_CLK_NS / 2) ref_clk_in = ~ref_clk_in;
  initial begin
    #(REF_CLK_NS * 20000);
    n_mismatch++;
    $display("watchdog expired");
    stop_test;
  end

  // monitors at the falling edge, where registered outputs have settled
  always @(negedge ref_clk_in) begin
    if (srst_in) begin
      have = 1'b0;
    end else if (rga_link_if_inst.tx_clk) begin
      lo   = rga_link_if_inst.txd;
      c1   = rga_link_if_inst.tx_ctl;
      have = 1'b1;
    end else if (have) begin
      have = 1'b0;
      if (c1) wire_q.push_back({c1 ^ rga_link_if_inst.tx_ctl, rga_link_if_inst.txd, lo});
    end
    if (ln_strobe && ln_tx_en) line_q.push_back({ln_tx_er, ln_tx_byte});
    // mac rx clock rises a cycle after the byte lands, mid-way through its life
    if (rx_clk_o && !rxc_d && (rx_valid || rx_error)) mac_q.push_back({rx_error, mac_rxd});
    rxc_d = rx_clk_o;
  end

  //////////////////////////////////////////////////////////////////////////////
  // push one byte; valid stays up so pushes can run back to back
  task push(input logic [7:0] b, input logic e);
    @(negedge ref_clk_in);
    {tx_valid, tx_en, tx_er, mac_txd} = {2'b11, e, b};
    @(posedge ref_clk_in);
    if (tx_ready === 1'b1) exp_tx.push_back({e, b});
    else saw_full = 1'b1;
  endtask

  // hand one byte to the phy end, held until it is taken
  task automatic send(input logic [7:0] b, input logic v, input logic e);
    @(negedge ref_clk_in);
    {ln_rx_byte, ln_rx_valid, ln_rx_error} = {b, v, e};
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      if (ln_take === 1'b1) break;
    end
  endtask

  // wait bounded for the bytes, then compare in order
  task automatic cmp_q(ref logic [8:0] e[$], ref logic [8:0] g[$]);
    for (int i = 0; i < 3000 && g.size() < e.size(); i++) @(negedge ref_clk_in);
    repeat (8) @(negedge ref_clk_in);
    `CHK(g.size(), e.size())
    foreach (e[i]) if (i < g.size()) `CHK(g[i], e[i])
    e.delete();
    g.delete();
  endtask

  task check_tx;
    logic [8:0] cp[$];
    cp = exp_tx;
    @(negedge ref_clk_in);
    tx_valid = 1'b0;
    cmp_q(cp, wire_q);
    cmp_q(exp_tx, line_q);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_tx_stream;
    push(8'h00, 1'b0);
    push(8'hff, 1'b0);
    push(8'ha5, 1'b1);
    push(8'h3c, 1'b0);
    check_tx;
    $display("test tx_stream done");
  endtask

  // pushes outrun the drain, so the buffer must refuse some
  task t_fifo_full;
    saw_full = 1'b0;
    for (int i = 0; i < 80; i++) push(i[7:0], i[2] & i[3]);
    check_tx;
    `CHK(saw_full, 1'b1)
    `CHK(tx_ready, 1'b1)
    $display("test fifo_full done");
  endtask

  task automatic t_rx_stream;
    logic [10:0] fr [5] = '{11'h612, 11'h6ed, 11'h75a, 11'h30f, 11'h680};
    foreach (fr[i]) begin
      send(fr[i][7:0], fr[i][10], fr[i][8]);
      exp_rx.push_back(fr[i][8:0]);
    end
    send(8'h00, 1'b0, 1'b0);
    cmp_q(exp_rx, mac_q);
    $display("test rx_stream done");
  endtask

  // idle bytes carry link, speed and duplex in the low nibble
  task automatic t_status;
    logic [3:0] st [3] = '{4'hb, 4'h4, 4'h7};
    foreach (st[i]) begin
      send({4'h0, st[i]}, 1'b0, 1'b0);
      repeat (16) @(negedge ref_clk_in);
      `CHK(link_up, st[i][0])
      `CHK(speed, st[i][2:1])
      `CHK(duplex, st[i][3])
    end
    $display("test status done");
  endtask

  // reset mid-stream, with status held up by the phy end
  task t_reset;
    push(8'h11, 1'b0);
    push(8'h22, 1'b0);
    @(negedge ref_clk_in);
    {srst_in, tx_valid} = 2'b10;
    repeat (2) @(negedge ref_clk_in);
    `CHK(rx_valid, 1'b0)
    `CHK(rx_error, 1'b0)
    `CHK(link_up, 1'b0)
    exp_tx.delete();
    wire_q.delete();
    line_q.delete();
    srst_in = 1'b0;
    @(negedge ref_clk_in);
    `CHK(tx_ready, 1'b1)
    push(8'h6b, 1'b1);
    check_tx;
    $display("test reset done");
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge ref_clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    t_tx_stream;
    t_fifo_full;
    t_rx_stream;
    t_status;
    t_reset;
    stop_test;
  end
endmodule
